// *** hdl/cbt_params.svh ***
/*
 * Constants for the command bus training pair: pin positions, field positions and timing.
 * Assumes a 100 MHz core clock on both ends.
 */
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH
`define CBT_CLK_PERIOD_NS 10
`define CBT_CA_WIDTH 6
`define CBT_DQ_WIDTH 16
`define CBT_ECHO_LSB 8
`define CBT_REF_WIDTH 7
`define CBT_REF_RANGE_BIT 6
`define CBT_REF_LEVEL_MSB 5
`define CBT_SETTLE_LONG_NS 250
`define CBT_SETTLE_SHORT_NS 80
`define CBT_CLK_HOLD_CKE_LOW_NS 5
`define CBT_CLK_HOLD_CKE_LOW_NCK 5
`define CBT_CLK_BEFORE_CKE_HIGH_NS 18
`define CBT_CLK_BEFORE_CKE_HIGH_NCK 3
`define CBT_CLK_BEFORE_SAMPLE_NCK 7
`define CBT_CLK_AFTER_SAMPLE_NCK 5
`define CBT_DQS_PULSES 2
`define CBT_CNT_WIDTH 8
`define CBT_CKE_IDLE_LEVEL 1'h1
`endif

// *** hdl/cbt_pkg.sv ***
/*
 * Types shared by both ends of the command bus training link.
 * Assumes cbt_params.svh for widths.
 */
`default_nettype none
`include "cbt_params.svh"
package cbt_pkg;
	typedef enum logic [1:0] {CBT_IDLE, CBT_TRAIN, CBT_SETTLE} cbt_dev_state_t;
	typedef enum logic [2:0] {
		CBT_H_IDLE, CBT_H_ENTER_HOLD, CBT_H_TRAIN, CBT_H_STROBE, CBT_H_EXIT_HOLD
	} cbt_host_state_t;
endpackage : cbt_pkg
`default_nettype wire

// *** hdl/cbt_link_if.sv ***
/*
 * Pin bundle between memory controller and DRAM die for command bus training.
 * Assumes one common clock; the two-way data pins are resolved from the enables here.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cbt_params.svh"
interface cbt_link_if;
	logic cke;
	logic cs;
	logic [`CBT_CA_WIDTH-1:0] ca;
	logic dqs;
	logic [`CBT_DQ_WIDTH-1:0] dq_host_o;
	logic [`CBT_DQ_WIDTH-1:0] dq_host_oe;
	logic [`CBT_DQ_WIDTH-1:0] dq_dev_o;
	logic [`CBT_DQ_WIDTH-1:0] dq_dev_oe;
	logic [`CBT_DQ_WIDTH-1:0] dq;
	always_comb begin
		for (int i = 0; i < `CBT_DQ_WIDTH; i++) begin
			dq[i] = dq_dev_oe[i] ? dq_dev_o[i] : (dq_host_oe[i] ? dq_host_o[i] : 1'b0);
		end
	end
	modport host (output cke, cs, ca, dqs, dq_host_o, dq_host_oe, input dq);
	modport dev (input cke, cs, ca, dqs, dq, output dq_dev_o, dq_dev_oe);
endinterface : cbt_link_if
`default_nettype wire

// *** hdl/cbt_device.sv ***
/*
 * DRAM die end of command bus training: CA echo, reference capture, set-point swap.
 * Assumes cke, dqs and DQ6:0 arrive from another domain in principle and are synchronised here; CA is echoed unsynchronised.
 */
// Function
// - Echo CA0..CA5 onto DQ8..DQ13 during training.
// - Controller clocks CK, holds CS low after CKE.
// - Controller may stop CK after hold time.
// - Controller keeps CK valid around CS samples.
// - Controller gives two or more strobe pulses.
// - Capture DQ6:0 each strobe edge, apply after settle.
// - Short settle only for single step cases.
// - CKE low selects inverse operating set point.
// - Controller preloads alternate set point registers.
// - No termination if alternate set disables it.
// - Grounded termination pad never enables termination; code rechecks the pad only in idle and at entry and exit.
// - Clock valid for interval before CKE high.
// - Clock back to original frequency at exit.
// - CS low for valid interval before CKE high.
// - CKE high restores original set point, termination.
// - Trained reference discarded on exit; host rewrites.
// - DQ5:0 level, DQ6 range into reference register.
// - CA echo path is combinational, unclocked.
`timescale 1ns/1ns
`default_nettype none
`include "cbt_params.svh"
module cbt_device
	import cbt_pkg::*;
#(
	parameter int SETTLE_LONG_CYC = (`CBT_SETTLE_LONG_NS + `CBT_CLK_PERIOD_NS - 1) / `CBT_CLK_PERIOD_NS,
	parameter int SETTLE_SHORT_CYC = (`CBT_SETTLE_SHORT_NS + `CBT_CLK_PERIOD_NS - 1) / `CBT_CLK_PERIOD_NS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	cbt_link_if.dev link,
	input wire logic train_enable_i,
	input wire logic set_point_select_i,
	input wire logic [1:0] ca_term_enable_i,
	input wire logic ca_term_pad_grounded_i,
	input wire logic [`CBT_REF_WIDTH-1:0] ca_reference_register_i [2],
	output logic training_o,
	output logic active_set_point_o,
	output logic ca_termination_o,
	output logic [`CBT_REF_WIDTH-1:0] ca_reference_level_o,
	output logic settling_o
);
	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	// The short wait must not outlast the long one, and both must fit the counter.
	if (SETTLE_LONG_CYC < 1 || SETTLE_SHORT_CYC < 1 || SETTLE_SHORT_CYC > SETTLE_LONG_CYC ||
		SETTLE_LONG_CYC >= 2**`CBT_CNT_WIDTH) begin : g_bad_settle
		$error("cbt_device: settle counts out of range");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		cbt_dev_state_t st;
		logic [1:0] cke_s;
		logic [1:0] dqs_s;
		logic dqs_last;
		logic [`CBT_REF_WIDTH-1:0] dq_s1;
		logic [`CBT_REF_WIDTH-1:0] dq_s2;
		logic [`CBT_REF_WIDTH-1:0] captured;
		logic [`CBT_REF_WIDTH-1:0] applied;
		logic [1:0] edge_count;
		logic dq_moved;
		logic [`CBT_CNT_WIDTH-1:0] settle_cnt;
		logic entry_set;
		logic active_set;
		logic [`CBT_REF_WIDTH-1:0] ref_out;
		logic term_out;
		logic training;
	} cbt_dev_st_t;
	cbt_dev_st_t s_reg, s_next;
	// The cke synchroniser resets to the idle-high level of its pin, so that the end of
	// reset is never taken for a falling cke and a spurious training entry.
	localparam cbt_dev_st_t DEV_RESET = '{st: CBT_IDLE, cke_s: {2{`CBT_CKE_IDLE_LEVEL}},
		default: '0};

	logic dqs_edge;
	logic one_step;
	logic short_allowed;
	logic settle_long_done;
	logic settle_short_done;
	logic [`CBT_CNT_WIDTH-1:0] settle_inc;
	logic [`CBT_REF_WIDTH-1:0] dq_ref;
	assign dq_ref = link.dq[`CBT_REF_WIDTH-1:0];
	assign dqs_edge = s_reg.dqs_s[1] ^ s_reg.dqs_last;

	// A single step means same range bit and level differing by one modulo 64, so levels 0 and 63 also count as a step.
	always_comb begin
		one_step = (s_reg.captured[`CBT_REF_RANGE_BIT] == s_reg.applied[`CBT_REF_RANGE_BIT]) &&
			((s_reg.captured[`CBT_REF_LEVEL_MSB:0] == s_reg.applied[`CBT_REF_LEVEL_MSB:0] + 6'h01) ||
			(s_reg.captured[`CBT_REF_LEVEL_MSB:0] + 6'h01 == s_reg.applied[`CBT_REF_LEVEL_MSB:0]));
	end

	// ----------------------------------------------------------------
	// Settling decision
	// ----------------------------------------------------------------
	// One strobe pulse yields at most two edges; a longer burst earns the short wait
	// only when every edge carried the same value. The long wait is always safe, so
	// any doubt falls back to it.
	always_comb begin
		settle_inc = s_reg.settle_cnt + 8'h01;
		short_allowed = one_step && (s_reg.edge_count <= 2'h2 || !s_reg.dq_moved);
		settle_long_done = (settle_inc >= SETTLE_LONG_CYC[`CBT_CNT_WIDTH-1:0]);
		settle_short_done = short_allowed &&
			(settle_inc >= SETTLE_SHORT_CYC[`CBT_CNT_WIDTH-1:0]);
	end

	// ----------------------------------------------------------------
	// Echo path
	// ----------------------------------------------------------------
	// The echo is deliberately unregistered so the controller sees the receiver's own latch.
	generate
		for (genvar g = 0; g < `CBT_DQ_WIDTH; g++) begin : g_echo
			if (g >= `CBT_ECHO_LSB && g < `CBT_ECHO_LSB + `CBT_CA_WIDTH) begin : g_on
				assign link.dq_dev_o[g] = link.ca[g - `CBT_ECHO_LSB];
				assign link.dq_dev_oe[g] = s_reg.training;
			end else begin : g_off
				assign link.dq_dev_o[g] = 1'b0;
				assign link.dq_dev_oe[g] = 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		// Cke, dqs and the reference pins pass two flops; only the second stage is read, plus its delayed copy dqs_last for dqs.
		s_next.cke_s = {s_reg.cke_s[0], link.cke};
		s_next.dqs_s = {s_reg.dqs_s[0], link.dqs};
		s_next.dqs_last = s_reg.dqs_s[1];
		s_next.dq_s1 = dq_ref;
		s_next.dq_s2 = s_reg.dq_s1;
		unique case (s_reg.st)
			CBT_IDLE: begin
				s_next.active_set = set_point_select_i;
				s_next.ref_out = ca_reference_register_i[set_point_select_i];
				s_next.term_out = ca_term_enable_i[set_point_select_i] & ~ca_term_pad_grounded_i;
				// Entry swaps to the alternate set at once; a grounded pad still wins.
				if (train_enable_i && !s_reg.cke_s[1]) begin
					s_next.st = CBT_TRAIN;
					s_next.training = 1'b1;
					s_next.entry_set = set_point_select_i;
					s_next.active_set = ~set_point_select_i;
					s_next.applied = ca_reference_register_i[~set_point_select_i];
					s_next.ref_out = ca_reference_register_i[~set_point_select_i];
					s_next.captured = ca_reference_register_i[~set_point_select_i];
					s_next.term_out = ca_term_enable_i[~set_point_select_i] & ~ca_term_pad_grounded_i;
					s_next.edge_count = 2'h0;
					s_next.dq_moved = 1'b0;
				end
			end
			CBT_TRAIN, CBT_SETTLE: begin
				if (dqs_edge) begin
					s_next.captured = s_reg.dq_s2;
					s_next.st = CBT_SETTLE;
					s_next.settle_cnt = '0;
					if (s_reg.edge_count != 2'h3)
						s_next.edge_count = s_reg.edge_count + 2'h1;
					if (s_reg.edge_count != 2'h0 && s_reg.dq_s2 != s_reg.captured)
						s_next.dq_moved = 1'b1;
				end else if (s_reg.st == CBT_SETTLE) begin
					s_next.settle_cnt = settle_inc;
					if (settle_long_done || settle_short_done) begin
						s_next.applied = s_reg.captured;
						s_next.ref_out = s_reg.captured;
						s_next.st = CBT_TRAIN;
						s_next.edge_count = 2'h0;
						s_next.dq_moved = 1'b0;
					end
				end
				// Leaving training drops whatever was trained; the controller has to write it
				// back into the set-point registers before it runs at the trained frequency.
				if (s_reg.cke_s[1]) begin
					s_next.st = CBT_IDLE;
					s_next.training = 1'b0;
					s_next.active_set = s_reg.entry_set;
					s_next.ref_out = ca_reference_register_i[s_reg.entry_set];
					s_next.term_out = ca_term_enable_i[s_reg.entry_set] & ~ca_term_pad_grounded_i;
				end
			end
			default: s_next.st = CBT_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_reg <= DEV_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign training_o = s_reg.training;
	assign active_set_point_o = s_reg.active_set;
	assign ca_termination_o = s_reg.term_out;
	assign ca_reference_level_o = s_reg.ref_out;
	assign settling_o = (s_reg.st == CBT_SETTLE);
endmodule : cbt_device
`default_nettype wire

// *** hdl/cbt_host.sv ***
/*
 * Memory controller end of command bus training: CKE, CS, CA, strobe and reference data.
 * Assumes the CK seen by the die is this clk_i; it never stops it.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cbt_params.svh"
module cbt_host
	import cbt_pkg::*;
#(
	parameter int HOLD_CYC = `CBT_CLK_HOLD_CKE_LOW_NCK,
	parameter int PRE_CKE_CYC = `CBT_CLK_HOLD_CKE_LOW_NCK,
	parameter int POST_SAMPLE_CYC = `CBT_CLK_AFTER_SAMPLE_NCK,
	parameter int PULSES = `CBT_DQS_PULSES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	cbt_link_if.host link,
	input wire logic enter_i,
	input wire logic exit_i,
	input wire logic sample_i,
	input wire logic [`CBT_CA_WIDTH-1:0] sample_ca_i,
	input wire logic ref_load_i,
	input wire logic [`CBT_REF_WIDTH-1:0] ref_value_i,
	output logic busy_o,
	output logic in_training_o,
	output logic [`CBT_CA_WIDTH-1:0] echo_o,
	output logic echo_valid_o
);
	if (PULSES < 2 || PULSES > 8 || HOLD_CYC < `CBT_CLK_HOLD_CKE_LOW_NCK ||
		PRE_CKE_CYC < `CBT_CLK_BEFORE_CKE_HIGH_NCK || POST_SAMPLE_CYC < 1) begin : g_bad_param
		$error("cbt_host: parameter out of range");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		cbt_host_state_t st;
		logic [`CBT_CNT_WIDTH-1:0] cnt;
		logic cke;
		logic cs;
		logic [`CBT_CA_WIDTH-1:0] ca;
		logic dqs;
		logic [`CBT_REF_WIDTH-1:0] dq;
		logic dq_oe;
		logic [`CBT_CA_WIDTH-1:0] echo_s1;
		logic [`CBT_CA_WIDTH-1:0] echo;
		logic [`CBT_CNT_WIDTH-1:0] echo_wait;
		logic echo_valid;
	} cbt_host_st_t;
	cbt_host_st_t s_reg, s_next;
	// Cke leaves reset at its normal high level, so the die never sees a false entry.
	localparam cbt_host_st_t HOST_RESET = '{st: CBT_H_IDLE, cke: `CBT_CKE_IDLE_LEVEL,
		default: '0};

	always_comb begin
		s_next = s_reg;
		s_next.echo_s1 = link.dq[`CBT_ECHO_LSB +: `CBT_CA_WIDTH];
		s_next.echo_valid = 1'b0;
		s_next.cs = 1'b0;
		if (s_reg.echo_wait != '0) begin
			s_next.echo_wait = s_reg.echo_wait - 8'h01;
			if (s_reg.echo_wait == 8'h01) begin
				s_next.echo = s_reg.echo_s1;
				s_next.echo_valid = 1'b1;
			end
		end
		unique case (s_reg.st)
			CBT_H_IDLE: begin
				s_next.cke = 1'b1;
				if (enter_i) begin
					s_next.cke = 1'b0;
					s_next.cnt = '0;
					s_next.st = CBT_H_ENTER_HOLD;
				end
			end
			CBT_H_ENTER_HOLD: begin
				s_next.cnt = s_reg.cnt + 8'h01;
				if (s_reg.cnt + 8'h01 >= HOLD_CYC[`CBT_CNT_WIDTH-1:0])
					s_next.st = CBT_H_TRAIN;
			end
			CBT_H_TRAIN: begin
				if (exit_i) begin
					s_next.cnt = '0;
					s_next.dq_oe = 1'b0;
					s_next.st = CBT_H_EXIT_HOLD;
				end else if (ref_load_i) begin
					s_next.dq = ref_value_i;
					s_next.dq_oe = 1'b1;
					s_next.cnt = '0;
					s_next.st = CBT_H_STROBE;
				end else if (sample_i && s_reg.echo_wait == '0) begin
					// The clock never stops here, so CK is valid around every sample.
					s_next.cs = 1'b1;
					s_next.ca = sample_ca_i;
					s_next.echo_wait = POST_SAMPLE_CYC[`CBT_CNT_WIDTH-1:0];
				end
			end
			CBT_H_STROBE: begin
				// Value held static across every edge so either settle time is legal.
				s_next.dqs = ~s_reg.dqs;
				s_next.cnt = s_reg.cnt + 8'h01;
				if (s_reg.cnt + 8'h01 >= 8'(2 * PULSES))
					s_next.st = CBT_H_TRAIN;
			end
			CBT_H_EXIT_HOLD: begin
				s_next.cnt = s_reg.cnt + 8'h01;
				if (s_reg.cnt + 8'h01 >= PRE_CKE_CYC[`CBT_CNT_WIDTH-1:0]) begin
					s_next.cke = 1'b1;
					s_next.st = CBT_H_IDLE;
				end
			end
			default: s_next.st = CBT_H_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_reg <= HOST_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign link.cke = s_reg.cke;
	assign link.cs = s_reg.cs;
	assign link.ca = s_reg.ca;
	assign link.dqs = s_reg.dqs;
	assign link.dq_host_o = {{(`CBT_DQ_WIDTH-`CBT_REF_WIDTH){1'b0}}, s_reg.dq};
	assign link.dq_host_oe = {{(`CBT_DQ_WIDTH-`CBT_REF_WIDTH){1'b0}},
		{`CBT_REF_WIDTH{s_reg.dq_oe}}};
	assign busy_o = (s_reg.st != CBT_H_IDLE) && (s_reg.st != CBT_H_TRAIN);
	assign in_training_o = (s_reg.st != CBT_H_IDLE);
	assign echo_o = s_reg.echo;
	assign echo_valid_o = s_reg.echo_valid;
endmodule : cbt_host
`default_nettype wire

// *** verif/cbt_link_assertions.sv ***
/* Checker for the command bus training link pins and the die's set-point status.
   Assumes the bench instantiates it once beside the link interface. */
`timescale 1ns/1ns
`default_nettype none
module cbt_link_assertions (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cke,
	input wire logic cs,
	input wire logic [5:0] ca,
	input wire logic dqs,
	input wire logic [15:0] dq,
	input wire logic [15:0] dq_dev_o,
	input wire logic [15:0] dq_dev_oe,
	input wire logic training_o,
	input wire logic active_set_point_o,
	input wire logic ca_termination_o,
	input wire logic ca_term_pad_grounded_i
);
	// ----------------------------------------------------------------
	// Link properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	echo_map_a: assert property (training_o |-> dq_dev_oe[13:8] == 6'h3F && dq[13:8] == ca)
		else $error("echo pins differ from CA");
	echo_idle_a: assert property (!training_o |-> dq_dev_oe == 16'h0000)
		else $error("die drives data outside training");
	term_pad_a: assert property (ca_term_pad_grounded_i && $past(ca_term_pad_grounded_i) |-> !ca_termination_o)
		else $error("termination on with grounded pad");
	cs_hold_a: assert property ($fell(cke) |-> !cs [*5])
		else $error("sample strobe during clock hold");
	strobe_pair_a: assert property ($rose(dqs) && !$past(dqs, 2) |-> ##1 !dqs ##1 dqs)
		else $error("strobe burst shorter than two pulses");
	dq_static_a: assert property ($changed(dqs) |-> $stable(dq[6:0]))
		else $error("reference data moved under strobe");
	exit_deselect_a: assert property ($rose(cke) |-> !$past(cs) && !$past(cs, 2) && !$past(cs, 3))
		else $error("sample strobe too close to exit");
	echo_off_a: assert property ($rose(cke) |-> ##[1:4] dq_dev_oe == 16'h0000)
		else $error("die still drives data after exit");
	swap_in_a: assert property ($rose(training_o) |-> !cke && active_set_point_o != $past(active_set_point_o))
		else $error("set point not swapped at entry");
	swap_out_a: assert property ($fell(training_o) |-> active_set_point_o != $past(active_set_point_o))
		else $error("set point not restored at exit");
endmodule : cbt_link_assertions
`default_nettype wire

// *** verif/testbench.sv ***
/* Bench joining controller and die ends over the link interface.
   Assumes the package, header and interface are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import cbt_pkg::*;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	localparam int SL = 25;
	logic clk_i, rst_i, enter_i, exit_i, sample_i, ref_load_i, train_enable_i, sp_i, gnd_i;
	logic [5:0] sample_ca_i, echo_o;
	logic [6:0] ref_value_i, level_o;
	logic [6:0] ref_regs [2];
	logic [1:0] term_en_i;
	logic busy_o, in_training_o, echo_valid_o, training_o, active_set_point_o, term_o, settling_o;
	int bad_count, cmp_count, cyc;
	cbt_link_if lnk();
	cbt_host i_cbt_host (.clk_i(clk_i), .rst_i(rst_i), .link(lnk), .enter_i(enter_i),
		.exit_i(exit_i), .sample_i(sample_i), .sample_ca_i(sample_ca_i), .ref_load_i(ref_load_i),
		.ref_value_i(ref_value_i), .busy_o(busy_o), .in_training_o(in_training_o),
		.echo_o(echo_o), .echo_valid_o(echo_valid_o));
	cbt_device i_cbt_device (.clk_i(clk_i), .rst_i(rst_i), .link(lnk),
		.train_enable_i(train_enable_i), .set_point_select_i(sp_i), .ca_term_enable_i(term_en_i),
		.ca_term_pad_grounded_i(gnd_i), .ca_reference_register_i(ref_regs),
		.training_o(training_o), .active_set_point_o(active_set_point_o),
		.ca_termination_o(term_o), .ca_reference_level_o(level_o), .settling_o(settling_o));
	cbt_link_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .cke(lnk.cke), .cs(lnk.cs),
		.ca(lnk.ca), .dqs(lnk.dqs), .dq(lnk.dq), .dq_dev_o(lnk.dq_dev_o),
		.dq_dev_oe(lnk.dq_dev_oe), .training_o(training_o),
		.active_set_point_o(active_set_point_o), .ca_termination_o(term_o),
		.ca_term_pad_grounded_i(gnd_i));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	function automatic logic pick(input int sel);
		case (sel)
			0: return busy_o;
			1: return training_o;
			2: return echo_valid_o;
			default: return settling_o;
		endcase
	endfunction : pick
	// A bounded wait; a wait that runs out counts as a mismatch.
	task automatic wait_until(input int sel, input logic lvl, output int n);
		n = 0;
		while (pick(sel) !== lvl && n < 200) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n >= 200) chk(8'h00, 8'h01);
	endtask : wait_until
	task automatic pulse(input int sel, input logic [6:0] d);
		@(posedge clk_i);
		enter_i <= (sel == 0);
		exit_i <= (sel == 1);
		sample_i <= (sel == 2);
		ref_load_i <= (sel == 3);
		sample_ca_i <= d[5:0];
		ref_value_i <= d;
		@(posedge clk_i);
		{enter_i, exit_i, sample_i, ref_load_i} <= 4'h0;
		#1;
	endtask : pulse
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic enter_cfg(input logic sp, input logic [1:0] en, input logic gnd);
		int n;
		@(posedge clk_i);
		sp_i <= sp;
		term_en_i <= en;
		gnd_i <= gnd;
		repeat (3) @(posedge clk_i);
		pulse(0, 7'h00);
		wait_until(0, 1'b0, n);
		wait_until(1, 1'b1, n);
		chk(active_set_point_o, !sp);
		chk(term_o, en[!sp] & !gnd);
		chk(level_o, ref_regs[!sp]);
		chk(in_training_o, 1'b1);
		chk(lnk.cke, 1'b0);
	endtask : enter_cfg
	task automatic leave_cfg();
		int n;
		pulse(1, 7'h00);
		wait_until(1, 1'b0, n);
		repeat (2) @(posedge clk_i);
		#1;
		chk(active_set_point_o, sp_i);
		chk(term_o, term_en_i[sp_i] & !gnd_i);
		chk(level_o, ref_regs[sp_i]);
		chk(in_training_o, 1'b0);
		chk(lnk.cke, 1'b1);
	endtask : leave_cfg
	task automatic echo_scan();
		int n;
		for (int i = 0; i < 6; i++) begin
			pulse(2, {1'b0, 6'h01 << i});
			wait_until(2, 1'b1, n);
			chk(echo_o, 6'h01 << i);
		end
	endtask : echo_scan
	// A single step with static data may settle short; any other change waits long.
	task automatic ref_step(input logic [6:0] v, input logic longw);
		int n;
		pulse(3, v);
		wait_until(3, 1'b1, n);
		wait_until(3, 1'b0, n);
		chk(n >= SL, longw);
		chk(level_o, v);
		wait_until(0, 1'b0, n);
	endtask : ref_step
	// With the training mode bit clear a low cke is a plain power-down: no swap, no echo.
	task automatic plain_cke_low();
		int n;
		@(posedge clk_i);
		train_enable_i <= 1'b0;
		pulse(0, 7'h00);
		wait_until(0, 1'b0, n);
		repeat (4) @(posedge clk_i);
		#1;
		chk(training_o, 1'b0);
		chk(active_set_point_o, sp_i);
		chk(lnk.dq_dev_oe[13:8], 6'h00);
		pulse(1, 7'h00);
		wait_until(0, 1'b0, n);
		repeat (4) @(posedge clk_i);
		@(posedge clk_i);
		train_enable_i <= 1'b1;
	endtask : plain_cke_low
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		{enter_i, exit_i, sample_i, ref_load_i} = 4'h0;
		sample_ca_i = 6'h00;
		ref_value_i = 7'h00;
		train_enable_i = 1'b1;
		sp_i = 1'b0;
		term_en_i = 2'b10;
		gnd_i = 1'b0;
		ref_regs[0] = 7'h0A;
		ref_regs[1] = 7'h10;
		bad_count = 0;
		cmp_count = 0;
		cyc = 0;
		rst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		enter_cfg(1'b0, 2'b10, 1'b0);
		echo_scan();
		ref_step(7'h25, 1'b1);
		ref_step(7'h26, 1'b0);
		ref_step(7'h28, 1'b1);
		ref_step(7'h68, 1'b1);
		leave_cfg();
		enter_cfg(1'b1, 2'b11, 1'b1);
		leave_cfg();
		enter_cfg(1'b1, 2'b10, 1'b0);
		leave_cfg();
		plain_cke_low();
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
